// File: verilog/sfcc_defines.vh
// Constants for the storage function combining controller.
// Assumes inclusion by bare name from the design files.
`ifndef SFCC_DEFINES_VH
`define SFCC_DEFINES_VH
`define SFCC_OFS_CAP_PTR   8'h34
`define SFCC_OFS_FUNC_DIS  8'hf2
`define SFCC_OFS_MAP       8'h90
`define SFCC_OFS_PORT_EN   8'h92
`define SFCC_OFS_CHAN_EN   8'h94
`define SFCC_OFS_STATUS    8'h96
`define SFCC_OFS_IDE_ID    8'h00
`define SFCC_OFS_TASK_CMD  8'h07
`define SFCC_BIT_IDE_HIDE  1
`define SFCC_BIT_MAP_COMB  0
`define SFCC_RST_FUNC_DIS  8'h00
`define SFCC_RST_MAP       8'h00
`define SFCC_RST_PORT_EN   8'h3f
`define SFCC_RST_CHAN_EN   8'h03
`define SFCC_CAP_NATIVE    8'h80
`define SFCC_CAP_COMBINED  8'h70
`define SFCC_IDE_ID_VAL    8'h5a
`define SFCC_NUM_PORTS     6
`define SFCC_FIFO_W        16
`define SFCC_FIFO_D        16
`define SFCC_FIFO_AW       4
`endif

// File: verilog/sfcc_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, active-low async reset and a clock enable.
`timescale 1ns/100ps
module sfcc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             ce,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_r;
  reg [AW:0]      rd_r;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  // Extra pointer bit separates full from empty without a counter.
  assign empty     = (wr_r == rd_r);
  assign full      = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_r[AW-1:0]];
  assign push      = ce && in_valid && !full;
  assign pop       = ce && out_ready && !empty;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= {(AW+1){1'b0}};
      rd_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= wr_r + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_r <= rd_r + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sfcc_fifo

// File: verilog/sfcc_ctrl.v
// Storage function combining controller: config space of the serial
// function, optional parallel IDE function, and a PIO data path.
// Assumes config cycles arrive as same-clock strobes; the drive's
// ide_dev_dmardy_n pin is asynchronous and is synchronised here.
// A hidden IDE function answers with a miss and all-ones data, as an
// absent function would, so probing software skips it cleanly.
// Config writes to a visible IDE function are acknowledged but dropped: it
// owns no writable register in this block.
// Function
// R1 - Native separate functions or one combined function
// R2 - Sharing routes all I/O decode via serial
// R3 - Disable bit 1 at F2h hides IDE
// R4 - Combined mode capability pointer shows no MSI
// R5 - Two link channels, each enabled, own DMA
// R6 - IDE-equivalent task register interface for software
// R7 - Software uses standard register and command conventions
// R8 - Serial link always runs at maximum speed
// R9 - Six serial ports individually enabled by firmware
// R10 - Ultra DMA lets host and target throttle
// R11 - One parallel IDE channel to connector
// R12 - Unhidden IDE function decodes separately and responds
`timescale 1ns/100ps
`include "sfcc_defines.vh"
module sfcc_ctrl (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        ce,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire        cfg_func,
  input  wire [7:0]  cfg_addr,
  input  wire [7:0]  cfg_wdata,
  output reg  [7:0]  cfg_rdata,
  output reg         cfg_ack,
  output reg         cfg_miss,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire        io_sel_ide,
  input  wire [15:0] io_wdata,
  output reg  [15:0] io_rdata,
  output reg         io_ack,
  output reg         io_wr_stall,
  output reg  [1:0]  dma_chan_act,
  output reg  [5:0]  sata_port_en,
  output reg         link_max_speed,
  output reg         ide_visible,
  output reg         ide_chan_en,
  input  wire        ide_dev_dmardy_n,
  output reg         ide_host_pause,
  output reg  [15:0] drv_wdata,
  output reg         drv_wvalid,
  input  wire        drv_wready
);
  reg [7:0]  func_dis_r;
  reg [7:0]  map_r;
  reg [7:0]  port_en_r;
  reg [7:0]  chan_en_r;
  reg [7:0]  cmd_r;
  reg        pin_meta_r;
  reg        pin_sync_r;
  wire       combined;
  wire       ide_hidden;
  wire       f_in_ready;
  wire [15:0] f_out_data;
  wire       f_out_valid;
  wire       f_out_ready;
  wire       ide_cfg_ok;
  wire       io_to_serial;
  wire       cfg_req;
  wire       cfg_wr_serial;

  ////////////////////////////////////////////////////////////////////
  assign combined   = map_r[`SFCC_BIT_MAP_COMB]; // R1
  assign ide_hidden = func_dis_r[`SFCC_BIT_IDE_HIDE]; // R3
  // R12
  assign ide_cfg_ok = !ide_hidden && !combined;
  // With sharing, even parallel-port I/O is claimed by the serial set.
  assign io_to_serial = combined || !io_sel_ide; // R2
  assign cfg_req       = cfg_wr || cfg_rd;
  // Only the serial function owns writable config registers.
  assign cfg_wr_serial = cfg_wr && !cfg_func;

  function [7:0] cfg_read;
    input [7:0] a;
    input       f;
    begin
      cfg_read = 8'h00;
      if (f) begin
        if (a == `SFCC_OFS_IDE_ID) begin
          cfg_read = `SFCC_IDE_ID_VAL; // arbitrary value
        end
      end else begin
        case (a)
          // R4
          `SFCC_OFS_CAP_PTR:
            cfg_read = combined ? `SFCC_CAP_COMBINED : `SFCC_CAP_NATIVE;
          `SFCC_OFS_FUNC_DIS: cfg_read = func_dis_r;
          `SFCC_OFS_MAP:      cfg_read = map_r;
          `SFCC_OFS_PORT_EN:  cfg_read = port_en_r;
          `SFCC_OFS_CHAN_EN:  cfg_read = chan_en_r;
          `SFCC_OFS_STATUS:
            cfg_read = {4'h0, f_out_valid, !f_in_ready, ide_hidden,
                        combined};
          default:            cfg_read = 8'h00;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Only the second flop is read, so a pin edge near the clock costs at
  // most one more cycle of pause but never a metastable decision.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else if (ce) begin
      pin_meta_r <= ide_dev_dmardy_n;
      pin_sync_r <= pin_meta_r;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      func_dis_r <= `SFCC_RST_FUNC_DIS;
      map_r      <= `SFCC_RST_MAP;
      port_en_r  <= `SFCC_RST_PORT_EN;
      chan_en_r  <= `SFCC_RST_CHAN_EN;
      cfg_rdata  <= 8'h00;
      cfg_ack    <= 1'b0;
      cfg_miss   <= 1'b0;
    end else if (ce) begin
      cfg_ack  <= 1'b0;
      cfg_miss <= 1'b0;
      if (cfg_req) begin
        if (cfg_func && !ide_cfg_ok) begin
          cfg_miss  <= 1'b1; // R3
          cfg_rdata <= 8'hff;
        end else begin
          cfg_ack   <= 1'b1;
          cfg_rdata <= cfg_rd ? cfg_read(cfg_addr, cfg_func) : 8'h00;
        end
      end
      if (cfg_wr_serial) begin
        case (cfg_addr)
          `SFCC_OFS_FUNC_DIS: func_dis_r <= cfg_wdata; // R3
          `SFCC_OFS_MAP:      map_r      <= cfg_wdata; // R1
          `SFCC_OFS_PORT_EN:  port_en_r  <= {2'b00, cfg_wdata[5:0]}; // R9
          `SFCC_OFS_CHAN_EN:  chan_en_r  <= {6'h00, cfg_wdata[1:0]}; // R5
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Task-file style I/O: every accepted 16-bit write goes through the FIFO to the
  // drive, and its low byte is also kept as the command/status byte read back.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_r          <= 8'h00;
      io_rdata       <= 16'h0000;
      io_ack         <= 1'b0;
      io_wr_stall    <= 1'b0;
      dma_chan_act   <= 2'b00;
      sata_port_en   <= 6'h00;
      link_max_speed <= 1'b1;
      ide_visible    <= 1'b1;
      ide_chan_en    <= 1'b0;
      ide_host_pause <= 1'b0;
    end else if (ce) begin
      io_ack <= (io_wr && f_in_ready) || io_rd; // R6
      io_wr_stall <= !f_in_ready;
      if (io_wr && f_in_ready) begin
        cmd_r <= io_wdata[7:0];
      end
      if (io_rd) begin
        io_rdata <= {7'h00, io_to_serial, cmd_r};
      end
      dma_chan_act   <= chan_en_r[1:0] & {2{f_out_valid}}; // R5
      sata_port_en   <= port_en_r[5:0]; // R9
      link_max_speed <= 1'b1; // R8
      ide_visible    <= ide_cfg_ok; // R12
      ide_chan_en    <= !ide_hidden; // R11
      // Host pauses when its FIFO is full or drive is not ready.
      ide_host_pause <= !f_in_ready || pin_sync_r; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Drive-side register keeps outputs flopped; target throttles via
  // its ready pin, synchronised, which back-pressures the FIFO.
  // The output stage holds one word more than the FIFO depth while the
  // drive stalls, so software sees one more write acknowledged.
  assign f_out_ready = !drv_wvalid || (drv_wready && !pin_sync_r); // R10

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drv_wdata  <= 16'h0000;
      drv_wvalid <= 1'b0;
    end else if (ce) begin
      if (f_out_ready) begin
        drv_wvalid <= f_out_valid;
        drv_wdata  <= f_out_data;
      end
    end
  end

  sfcc_fifo #(
    .WIDTH (`SFCC_FIFO_W),
    .DEPTH (`SFCC_FIFO_D),
    .AW    (`SFCC_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .in_data   (io_wdata),
    .in_valid  (io_wr),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );
endmodule // sfcc_ctrl

// File: testbench/sfcc_ctrl_asserts.sv
// Port checker for the storage function combining controller.
// Assumes one clock domain and binding onto sfcc_ctrl.
`timescale 1ns/100ps
module sfcc_ctrl_asserts (
  input wire        clk,
  input wire        reset_n,
  input wire        ce,
  input wire        cfg_wr,
  input wire        cfg_rd,
  input wire        cfg_func,
  input wire [7:0]  cfg_rdata,
  input wire        cfg_ack,
  input wire        cfg_miss,
  input wire        io_rd,
  input wire        io_ack,
  input wire        ide_visible,
  input wire        link_max_speed,
  input wire        ide_dev_dmardy_n,
  input wire        ide_host_pause,
  input wire [15:0] drv_wdata,
  input wire        drv_wvalid,
  input wire        drv_wready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A write just before lets the visibility flag lag one cycle.
  sequence s_ide_rd;
    ce && cfg_rd && cfg_func && !$past(cfg_wr);
  endsequence
  AST_LINK: assert property (link_max_speed)
    else $error("link not at max speed");
  AST_CFG: assert property (ce && (cfg_wr || cfg_rd) |=> cfg_ack || cfg_miss)
    else $error("config request unanswered");
  AST_HIDE: assert property (s_ide_rd ##0 !ide_visible |=> cfg_miss && cfg_rdata == 8'hff)
    else $error("hidden function answered");
  AST_VIS: assert property (s_ide_rd ##0 ide_visible |=> cfg_ack)
    else $error("visible function missed");
  AST_IORD: assert property (ce && io_rd |=> io_ack)
    else $error("io read unanswered");
  AST_PAUSE: assert property ((ce && ide_dev_dmardy_n) [*4] |-> ide_host_pause)
    else $error("drive throttle ignored");
  AST_HOLD: assert property (drv_wvalid && !drv_wready |=> drv_wvalid && $stable(drv_wdata))
    else $error("drive word dropped");
  AST_MISS: assert property (cfg_miss |-> !cfg_ack)
    else $error("miss and ack together");
endmodule // sfcc_ctrl_asserts
bind sfcc_ctrl sfcc_ctrl_asserts sfcc_ctrl_asserts_i (.clk, .reset_n, .ce,
  .cfg_wr, .cfg_rd, .cfg_func, .cfg_rdata, .cfg_ack, .cfg_miss, .io_rd,
  .io_ack, .ide_visible, .link_max_speed, .ide_dev_dmardy_n, .ide_host_pause,
  .drv_wdata, .drv_wvalid, .drv_wready);

// File: testbench/sfcc_drv_model.sv
// Drive-side model: takes words and throttles through its ready pins.
// Assumes the bench raises stall to make the drive not ready.
`timescale 1ns/100ps
module sfcc_drv_model (
  input  wire        clk,
  input  wire        stall,
  input  wire [15:0] drv_wdata,
  input  wire        drv_wvalid,
  output reg         drv_wready,
  output reg         ide_dev_dmardy_n
);
  logic [15:0] got [$];
  reg   [1:0]  sh_n = 2'b11;
  initial begin
    drv_wready = 1'b0;
    ide_dev_dmardy_n = 1'b1;
  end
  // The host sees the ready pin two flops late, so count with that delay.
  always @(posedge clk) begin
    if (drv_wvalid && drv_wready && !sh_n[1]) got.push_back(drv_wdata);
    sh_n <= {sh_n[0], ide_dev_dmardy_n};
    drv_wready <= !stall;
    ide_dev_dmardy_n <= stall;
  end
endmodule // sfcc_drv_model

// File: testbench/testbench.sv
// Self-checking bench for sfcc_ctrl with the drive model beside it.
// Assumes a 200 MHz clock; inputs change at the falling edge.
`timescale 1ns/100ps
`include "sfcc_defines.vh"
module testbench;
  reg          clk = 0, reset_n = 0, stall = 1, cfg_wr = 0, cfg_rd = 0;
  reg          cfg_func = 0, io_wr = 0, io_rd = 0, io_sel_ide = 0, ce = 1;
  reg  [7:0]   cfg_addr = 0, cfg_wdata = 0;
  reg  [15:0]  io_wdata = 0;
  wire [7:0]   cfg_rdata;
  wire [15:0]  io_rdata, drv_wdata;
  wire [5:0]   sata_port_en;
  wire [1:0]   dma_chan_act;
  wire         cfg_ack, cfg_miss, io_ack, io_wr_stall, link_max_speed;
  wire         ide_visible, ide_chan_en, ide_dev_dmardy_n, ide_host_pause;
  wire         drv_wvalid, drv_wready;
  integer      failures = 0, n_tests = 0, cycles = 0, i;
  logic [15:0] sent [$];
  sfcc_ctrl sfcc_ctrl_i (.clk, .reset_n, .ce, .cfg_wr, .cfg_rd,
    .cfg_func, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_ack, .cfg_miss,
    .io_wr, .io_rd, .io_sel_ide, .io_wdata, .io_rdata, .io_ack, .io_wr_stall,
    .dma_chan_act, .sata_port_en, .link_max_speed, .ide_visible, .ide_chan_en,
    .ide_dev_dmardy_n, .ide_host_pause, .drv_wdata, .drv_wvalid, .drv_wready);
  sfcc_drv_model sfcc_drv_model_i (.clk, .stall, .drv_wdata, .drv_wvalid,
    .drv_wready, .ide_dev_dmardy_n);
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task cfg(input w, f, input [7:0] a, d, output [7:0] r, output m);
    @(negedge clk);
    {cfg_wr, cfg_rd, cfg_func, cfg_addr, cfg_wdata} = {w, !w, f, a, d};
    @(negedge clk);
    {cfg_wr, cfg_rd} = 2'b00;
    r = cfg_rdata;
    m = cfg_miss;
    chk("cfg answer", {15'h0000, cfg_ack ^ cfg_miss}, 16'h0001);
  endtask
  task io(input w, s, input [15:0] d, output [15:0] r, output a);
    @(negedge clk);
    {io_wr, io_rd, io_sel_ide, io_wdata} = {w, !w, s, d};
    @(negedge clk);
    {io_wr, io_rd} = 2'b00;
    r = io_rdata;
    a = io_ack;
  endtask
  // Each entry: write, function, offset, data or expected read, miss.
  task t_modes;
    reg [7:0]  r;
    reg        m;
    reg [18:0] tb [0:11];
    tb = '{{2'b00, 8'h34, 8'h80, 1'b0}, {2'b01, 8'h00, 8'h5a, 1'b0},
      {2'b00, 8'h92, 8'h3f, 1'b0}, {2'b00, 8'h94, 8'h03, 1'b0},
      {2'b10, 8'h90, 8'h01, 1'b0}, {2'b00, 8'h34, 8'h70, 1'b0},
      {2'b01, 8'h00, 8'hff, 1'b1}, {2'b10, 8'h90, 8'h00, 1'b0},
      {2'b10, 8'hf2, 8'h02, 1'b0}, {2'b01, 8'h00, 8'hff, 1'b1},
      {2'b10, 8'hf2, 8'h00, 1'b0}, {2'b01, 8'h00, 8'h5a, 1'b0}};
    for (i = 0; i < 12; i++) begin
      cfg(tb[i][18], tb[i][17], tb[i][16:9], tb[i][8:1], r, m);
      chk("cfg miss", {15'h0000, m}, {15'h0000, tb[i][0]});
      if (!tb[i][18]) chk("cfg rdata", r, tb[i][8:1]);
    end
  endtask
  // The drive stalls first so the buffer must fill and refuse.
  task t_io;
    reg [15:0] r;
    reg [7:0]  c;
    reg        a;
    io(0, 1, 16'h0000, r, a);
    chk("native decode", r[8], 0);
    cfg(1, 0, 8'h90, 8'h01, c, a);
    io(0, 1, 16'h0000, r, a);
    chk("shared decode", r[8], 1);
    cfg(1, 0, 8'h90, 8'h00, c, a);
    for (i = 0; i < 20; i++) begin
      io(1, 0, 16'ha500 + i[15:0], r, a);
      if (a) sent.push_back(16'ha500 + i[15:0]);
    end
    chk("refused", 16'(sent.size()), `SFCC_FIFO_D + 1);
    chk("wr stall", io_wr_stall, 1);
    chk("pause", ide_host_pause, 1);
    chk("dma busy", dma_chan_act, 16'h0003);
    stall = 0;
    for (i = 0; i < 300 && sfcc_drv_model_i.got.size() < sent.size(); i++)
      @(negedge clk);
    repeat (3) @(negedge clk);
    chk("drained", 16'(sfcc_drv_model_i.got.size()), 16'(sent.size()));
    foreach (sent[k]) chk("word", sfcc_drv_model_i.got[k], sent[k]);
    chk("dma idle", dma_chan_act, 0);
    chk("pause off", ide_host_pause, 0);
  endtask
  // Firmware trims ports and channels; a low clock enable freezes all.
  task t_ports;
    reg [15:0] r;
    reg [7:0]  c;
    reg        m;
    cfg(1, 0, 8'h92, 8'h15, c, m);
    cfg(1, 0, 8'h94, 8'h01, c, m);
    @(negedge clk);
    chk("port trim", sata_port_en, 16'h0015);
    @(negedge clk);
    {ce, cfg_wr, cfg_addr, cfg_wdata} = {1'b0, 1'b1, 8'h92, 8'h00};
    @(negedge clk);
    cfg_wr = 1'b0;
    chk("frozen ack", {15'h0000, cfg_ack}, 16'h0000);
    @(negedge clk);
    chk("frozen ports", sata_port_en, 16'h0015);
    ce = 1'b1;
    cfg(0, 0, 8'h92, 8'h00, c, m);
    chk("ports kept", c, 16'h0015);
    io(1, 0, 16'h12c3, r, m);
    @(negedge clk);
    chk("one channel", dma_chan_act, 16'h0001);
    io(0, 0, 16'h0000, r, m);
    chk("io echo", r, 16'h01c3);
    chk("last word", sfcc_drv_model_i.got[$], 16'h12c3);
    cfg(1, 0, 8'hf2, 8'h02, c, m);
    @(negedge clk);
    chk("ide channel off", ide_chan_en, 0);
    chk("ide hidden", ide_visible, 0);
    cfg(1, 0, 8'hf2, 8'h00, c, m);
    @(negedge clk);
    chk("ide channel on", ide_chan_en, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    reset_n = 1;
    @(negedge clk);
    chk("port enables", sata_port_en, 16'h003f);
    chk("max speed", link_max_speed, 1);
    t_modes;
    t_io;
    t_ports;
    stop_test;
  end
endmodule // testbench
